//--- flash_cmd_pkg.sv
// Constants and types shared by the flash command decoder and its bus sampler
package flash_cmd_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  // Command bytes and unlock addresses
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_CONFIG = 8'hc0;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
  // Configuration field positions in the third cycle address
  localparam int WS_LSB = 12;
  localparam int WS_MSB = 14;
  localparam int BT_LSB = 15;
  localparam int BT_MSB = 16;
  // Values after reset, and the latency offset added to the wait-state code
  localparam logic [2:0] WS_RESET = 3'h5;
  localparam logic [1:0] BT_RESET = 2'h0;
  localparam logic [3:0] LAT_OFFSET = 4'h2;
  // Sector map
  localparam logic [21:0] UPPER_BANK_BASE = 22'h300000;
  localparam logic [6:0] BOOT_TOP_LOW = 7'h5f;
  localparam logic [6:0] BOOT_TOP_HIGH = 7'h7f;
  // Burst wrap grouping
  localparam logic [5:0] WRAP8_MASK = 6'h07;
  localparam logic [5:0] WRAP16_MASK = 6'h0f;
  localparam logic [5:0] WRAP32_MASK = 6'h1f;
  // Handshaking code reported by autoselect
  localparam logic [15:0] HANDSHAKE_CODE = 16'h0043;
  localparam logic [5:0] AUTOSEL_HS_OFS = 6'h03;
  // Interrupt status bits
  localparam int EV_CFG = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_DONE = 2;
  localparam int EV_W = 3;

  typedef enum logic [5:0] {
    ST_READ    = 6'b000001,
    ST_UNLK1   = 6'b000010,
    ST_UNLK2   = 6'b000100,
    ST_BUSY    = 6'b001000,
    ST_AUTOSEL = 6'b010000,
    ST_TIMEOUT = 6'b100000
  } cmd_state_t;
endpackage

//--- bus_cap_if.sv
// Interface carrying captured bus cycles from the sampler to the decoder
`timescale 1ns/1ps
interface bus_cap_if;
  logic addr_stb;
  logic [flash_cmd_pkg::ADDR_W-1:0] addr;
  logic data_stb;
  logic [flash_cmd_pkg::DATA_W-1:0] data;
  logic clk_rise;
  modport src (output addr_stb, addr, data_stb, data, clk_rise);
  modport dst (input addr_stb, addr, data_stb, data, clk_rise);
endinterface

//--- bus_sampler.sv
// Synchronises the flash bus pins and captures address and write data on strobe edges
`timescale 1ns/1ps
module bus_sampler (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic address_valid_strobe_n,
  input wire logic write_strobe_n,
  input wire logic burst_clk,
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] addr_pin,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] dq_in,
  bus_cap_if.src cap
);
  logic [1:0] avd_s_q, we_s_q, clk_s_q;
  logic avd_d_q, we_d_q, clk_d_q;
  logic [flash_cmd_pkg::ADDR_W-1:0] addr_s1_q, addr_s2_q;
  logic [flash_cmd_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;

  // Two-stage synchronisers; only the second stage is read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avd_s_q <= 2'h3;
      we_s_q <= 2'h3;
      clk_s_q <= 2'h0;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      avd_d_q <= 1'b1;
      we_d_q <= 1'b1;
      clk_d_q <= 1'b0;
    end else begin
      avd_s_q <= {avd_s_q[0], address_valid_strobe_n};
      we_s_q <= {we_s_q[0], write_strobe_n};
      clk_s_q <= {clk_s_q[0], burst_clk};
      addr_s1_q <= addr_pin;
      addr_s2_q <= addr_s1_q;
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      avd_d_q <= avd_s_q[1];
      we_d_q <= we_s_q[1];
      clk_d_q <= clk_s_q[1];
    end
  end

  // Rising edges of the strobes latch address and data; bus is assumed held
  always_comb begin
    cap.addr_stb = avd_s_q[1] & ~avd_d_q;
    cap.data_stb = we_s_q[1] & ~we_d_q;
    cap.addr = addr_s2_q;
    cap.data = dq_s2_q;
    cap.clk_rise = clk_s_q[1] & ~clk_d_q;
  end
endmodule

//--- flash_read_mode_burst_config.sv
// Command decoder, read-mode control and burst configuration of the flash
// Functional notes
// - Wrong address, data or order in a command sequence returns to array read; the code takes 90h into autoselect at any third-cycle address.
// - Address taken at address strobe rise, data at write strobe rise.
// - Power-up leaves the device in array read with no command needed.
// - A bank finishing program or erase returns itself to array read.
// - Erase suspend gives suspend-read; suspended sector reads are blocked.
// - Timeout flag or autoselect holds the bank until reset command.
// - Configuration is two unlock writes then C0h, setting in the address.
// - Setting decoded from address 16..12; address 19..17 ignored.
// - Wait-state code 0..5 gives initial latency code plus two clocks.
// - Address 16..15 selects continuous, 8, 16 or 32 word wrap burst.
// - Power-up default is seven cycles of initial latency.
// - Hardware reset restores the default wait-state setting.
// - Typical latency grows by one for odd start, two at boundary.
// - Wrapped bursts stay inside their group, never crossing 64 words.
// - Autoselect reports whether handshaking is enabled.
// - 32K sectors except eight 8K boot sectors; upper bank at 300000h.
`timescale 1ns/1ps
module flash_read_mode_burst_config (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic address_valid_strobe_n,
  input wire logic write_strobe_n,
  input wire logic burst_clk,
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] addr_pin,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] dq_in,
  input wire logic op_start,
  input wire logic op_done,
  input wire logic timeout_flag_bit,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  output logic [3:0] latency_q,
  output logic [1:0] burst_type_q,
  output logic [flash_cmd_pkg::ADDR_W-1:0] burst_addr_q,
  output logic [7:0] sector_q,
  output logic upper_bank_q,
  output logic read_blocked_q,
  output logic suspend_read_q,
  output logic [15:0] autosel_data_q,
  output logic [3:0] ready_cycles_q
);
  localparam logic [3:0] RA_STATUS = 4'h0;
  localparam logic [3:0] RA_MASK = 4'h1;
  localparam logic [3:0] RA_CONFIG = 4'h2;
  localparam logic [3:0] RA_STATE = 4'h3;

  bus_cap_if cap ();

  bus_sampler u_sampler (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .address_valid_strobe_n(address_valid_strobe_n),
    .write_strobe_n(write_strobe_n),
    .burst_clk(burst_clk),
    .addr_pin(addr_pin),
    .dq_in(dq_in),
    .cap(cap)
  );

  flash_cmd_pkg::cmd_state_t state_q;
  logic [flash_cmd_pkg::ADDR_W-1:0] addr_lat_q;
  logic [2:0] ws_q;
  logic suspended_q;
  logic [7:0] susp_sector_q;
  logic [flash_cmd_pkg::EV_W-1:0] status_q, mask_q, ev;
  logic [1:0] op_s_q, done_s_q, to_s_q;
  logic done_d_q, start_d_q;
  logic op_start_p, op_done_p, timeout_lvl;
  logic [7:0] cmd;
  logic [11:0] low_addr;
  logic cfg_hit, abort_hit;
  logic [7:0] sect_of_lat;
  logic [5:0] wrap_mask;

  // Event inputs from the embedded engine come from another domain
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_s_q <= 2'h0;
      done_s_q <= 2'h0;
      to_s_q <= 2'h0;
      done_d_q <= 1'b0;
      start_d_q <= 1'b0;
    end else begin
      op_s_q <= {op_s_q[0], op_start};
      done_s_q <= {done_s_q[0], op_done};
      to_s_q <= {to_s_q[0], timeout_flag_bit};
      done_d_q <= done_s_q[1];
      start_d_q <= op_s_q[1];
    end
  end

  assign op_start_p = op_s_q[1] & ~start_d_q;
  assign op_done_p = done_s_q[1] & ~done_d_q;
  assign timeout_lvl = to_s_q[1];
  assign cmd = cap.data[7:0];
  assign low_addr = addr_lat_q[11:0];

  // Latest address latched on each address strobe rise
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_lat_q <= '0;
    end else if (cap.addr_stb) begin
      addr_lat_q <= cap.addr;
    end
  end

  // Sector index for a word address; boot regions split into 8K sectors
  function automatic logic [7:0] sector_of(input logic [21:0] a);
    logic [6:0] blk;
    logic [7:0] res;
    blk = a[21:15];
    res = {1'b0, blk};
    if (blk > flash_cmd_pkg::BOOT_TOP_LOW) begin
      res = {1'b0, blk} + 8'h03;
    end
    if (blk == flash_cmd_pkg::BOOT_TOP_LOW) begin
      res = {1'b0, blk} + {6'h00, a[14:13]};
    end
    if (blk == flash_cmd_pkg::BOOT_TOP_HIGH) begin
      res = {1'b0, blk} + 8'h03 + {6'h00, a[14:13]};
    end
    return res;
  endfunction

  assign sect_of_lat = sector_of(addr_lat_q);
  assign cfg_hit = (state_q == flash_cmd_pkg::ST_UNLK2) && cap.data_stb
    && (cmd == flash_cmd_pkg::CMD_CONFIG) && (low_addr == flash_cmd_pkg::UNLOCK_ADDR1);
  assign abort_hit = cap.data_stb && ((state_q == flash_cmd_pkg::ST_UNLK1)
    || (state_q == flash_cmd_pkg::ST_UNLK2)) && !cfg_hit
    && !((state_q == flash_cmd_pkg::ST_UNLK1) && (cmd == flash_cmd_pkg::CMD_UNLOCK2)
    && (low_addr == flash_cmd_pkg::UNLOCK_ADDR2))
    && !((state_q == flash_cmd_pkg::ST_UNLK2) && (cmd == flash_cmd_pkg::CMD_AUTOSEL));

  // Command sequence state machine; reset leaves array read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= flash_cmd_pkg::ST_READ;
    end else begin
      unique case (state_q)
        flash_cmd_pkg::ST_READ: begin
          if (op_start_p) begin
            state_q <= flash_cmd_pkg::ST_BUSY;
          end else if (cap.data_stb && cmd == flash_cmd_pkg::CMD_UNLOCK1
              && low_addr == flash_cmd_pkg::UNLOCK_ADDR1) begin
            state_q <= flash_cmd_pkg::ST_UNLK1;
          end
        end
        flash_cmd_pkg::ST_UNLK1: begin
          if (cap.data_stb) begin
            if (cmd == flash_cmd_pkg::CMD_UNLOCK2 && low_addr == flash_cmd_pkg::UNLOCK_ADDR2) begin
              state_q <= flash_cmd_pkg::ST_UNLK2;
            end else begin
              state_q <= flash_cmd_pkg::ST_READ;
            end
          end
        end
        flash_cmd_pkg::ST_UNLK2: begin
          if (cap.data_stb) begin
            if (cmd == flash_cmd_pkg::CMD_AUTOSEL) begin
              state_q <= flash_cmd_pkg::ST_AUTOSEL;
            end else begin
              state_q <= flash_cmd_pkg::ST_READ;
            end
          end
        end
        flash_cmd_pkg::ST_BUSY: begin
          if (timeout_lvl) begin
            state_q <= flash_cmd_pkg::ST_TIMEOUT;
          end else if (op_done_p) begin
            state_q <= flash_cmd_pkg::ST_READ;
          end
        end
        flash_cmd_pkg::ST_AUTOSEL, flash_cmd_pkg::ST_TIMEOUT: begin
          // Only the reset command leaves; other writes are ignored
          if (cap.data_stb && cmd == flash_cmd_pkg::CMD_RESET) begin
            state_q <= flash_cmd_pkg::ST_READ;
          end
        end
        default: state_q <= flash_cmd_pkg::ST_READ;
      endcase
    end
  end

  // Erase suspend tracking; suspended sector is remembered across programs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      suspended_q <= 1'b0;
      susp_sector_q <= 8'h00;
    end else if (cap.data_stb && state_q == flash_cmd_pkg::ST_READ) begin
      if (cmd == flash_cmd_pkg::CMD_SUSPEND) begin
        suspended_q <= 1'b1;
        susp_sector_q <= sect_of_lat;
      end else if (cmd == flash_cmd_pkg::CMD_RESUME && suspended_q) begin
        suspended_q <= 1'b0;
      end
    end
  end

  // Configuration write updates latency and burst type
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ws_q <= flash_cmd_pkg::WS_RESET;
      burst_type_q <= flash_cmd_pkg::BT_RESET;
    end else if (cfg_hit) begin
      // Address 19..17 unused; code 6 or 7 kept as is, an illegal setting
      ws_q <= addr_lat_q[flash_cmd_pkg::WS_MSB:flash_cmd_pkg::WS_LSB];
      burst_type_q <= addr_lat_q[flash_cmd_pkg::BT_MSB:flash_cmd_pkg::BT_LSB];
    end
  end

  // Latency is code plus two
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latency_q <= 4'h7;
    end else begin
      latency_q <= {1'b0, ws_q} + flash_cmd_pkg::LAT_OFFSET;
    end
  end

  // Wrap group for the selected burst type
  always_comb begin
    unique case (burst_type_q)
      2'h1: wrap_mask = flash_cmd_pkg::WRAP8_MASK;
      2'h2: wrap_mask = flash_cmd_pkg::WRAP16_MASK;
      2'h3: wrap_mask = flash_cmd_pkg::WRAP32_MASK;
      default: wrap_mask = 6'h3f;
    endcase
  end

  // Burst pointer loads on address strobe and steps on each burst clock rise
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      burst_addr_q <= '0;
    end else if (cap.addr_stb) begin
      burst_addr_q <= cap.addr;
    end else if (cap.clk_rise) begin
      if (burst_type_q == 2'h0) begin
        burst_addr_q <= burst_addr_q + 22'h000001;
      end else begin
        // Only low bits inside the group advance, so no 64-word crossing
        burst_addr_q[5:0] <= (burst_addr_q[5:0] & ~wrap_mask)
          | ((burst_addr_q[5:0] + 6'h01) & wrap_mask);
      end
    end
  end

  // Typical first-data count: odd start adds one, boundary crossing two
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ready_cycles_q <= 4'h0;
    end else if (cap.addr_stb) begin
      ready_cycles_q <= latency_q + {3'h0, cap.addr[0]}
        + ((burst_type_q == 2'h0 && cap.addr[5:0] >= 6'h3e) ? 4'h2 : 4'h0);
    end
  end

  // Sector decode, bank and read blocking outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sector_q <= 8'h00;
      upper_bank_q <= 1'b0;
      read_blocked_q <= 1'b0;
      suspend_read_q <= 1'b0;
    end else begin
      sector_q <= sect_of_lat;
      upper_bank_q <= addr_lat_q >= flash_cmd_pkg::UPPER_BANK_BASE;
      read_blocked_q <= suspended_q && (sect_of_lat == susp_sector_q);
      suspend_read_q <= suspended_q && state_q == flash_cmd_pkg::ST_READ;
    end
  end

  // Autoselect read data: handshaking enabled code at its offset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      autosel_data_q <= 16'h0000;
    end else if (state_q == flash_cmd_pkg::ST_AUTOSEL
        && addr_lat_q[5:0] == flash_cmd_pkg::AUTOSEL_HS_OFS) begin
      autosel_data_q <= flash_cmd_pkg::HANDSHAKE_CODE;
    end else begin
      autosel_data_q <= 16'h0000;
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_comb begin
    ev = '0;
    ev[flash_cmd_pkg::EV_CFG] = cfg_hit;
    ev[flash_cmd_pkg::EV_ABORT] = abort_hit;
    ev[flash_cmd_pkg::EV_DONE] = op_done_p && state_q == flash_cmd_pkg::ST_BUSY;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= '0;
      mask_q <= '0;
    end else begin
      if (reg_wr && reg_addr == RA_STATUS) begin
        status_q <= (status_q & ~reg_wdata[flash_cmd_pkg::EV_W-1:0]) | ev;
      end else begin
        status_q <= status_q | ev;
      end
      if (reg_wr && reg_addr == RA_MASK) begin
        mask_q <= reg_wdata[flash_cmd_pkg::EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        RA_STATUS: reg_rdata <= {13'h0000, status_q};
        RA_MASK: reg_rdata <= {13'h0000, mask_q};
        RA_CONFIG: reg_rdata <= {7'h00, burst_type_q, ws_q, latency_q};
        RA_STATE: reg_rdata <= {9'h000, suspended_q, state_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule

//--- flash_cfg_chk.sv
// Port assertions for the flash command decoder
`timescale 1ns/1ps
module flash_cfg_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic write_strobe_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [3:0] latency_q,
  input wire logic [1:0] burst_type_q,
  input wire logic [7:0] sector_q,
  input wire logic upper_bank_q,
  input wire logic [15:0] autosel_data_q
);
  logic [3:0] quiet_q;
  // Cycles since the write strobe was low; saturates so it never wraps
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      quiet_q <= 4'hf;
    end else if (!write_strobe_n) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  AST_RST_LAT: assert property ($rose(arst_n) |-> latency_q == 4'h7)
    else $error("latency not seven after reset");
  AST_LAT_MIN: assert property (latency_q >= 4'h2)
    else $error("latency below two");
  AST_LAT_CAUSE: assert property (!$stable(latency_q) |-> quiet_q < 4'hc)
    else $error("latency changed without a write");
  AST_BT_CAUSE: assert property (!$stable(burst_type_q) |-> quiet_q < 4'hc)
    else $error("burst type changed without a write");
  AST_UPPER: assert property (upper_bank_q == (sector_q >= 8'h63))
    else $error("bank flag disagrees with sector");
  AST_SEC_MAX: assert property (sector_q <= 8'h85)
    else $error("sector index out of range");
  AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside its cycle");
  AST_AUTOSEL: assert property (autosel_data_q == 16'h0 || autosel_data_q == 16'h0043)
    else $error("bad autoselect data");
endmodule

//--- flash_host_model.sv
// Host controller model driving the multiplexed burst bus
`timescale 1ns/1ps
module flash_host_model (
  input wire logic clk_sys,
  output logic address_valid_strobe_n,
  output logic write_strobe_n,
  output logic burst_clk,
  output logic [21:0] addr_pin,
  output logic [15:0] dq_in
);
  // Idle bus at time zero; the burst clock stands still outside bursts
  initial begin
    address_valid_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    burst_clk = 1'b0;
    addr_pin = 22'h0;
    dq_in = 16'h0;
  end
  // Address phase held four edges either side of the strobe rise
  task automatic latch(input logic [21:0] a);
    @(posedge clk_sys);
    addr_pin <= a;
    address_valid_strobe_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    address_valid_strobe_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    addr_pin <= ~a; // Released pins never show the old address
  endtask
  // Address phase, then data phase
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    latch(a);
    dq_in <= d;
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    dq_in <= ~d;
  endtask
  // Short burst at 80 ns, offset from the system clock edges
  task automatic burst(input int n);
    #3;
    repeat (n) begin
      burst_clk = 1'b1;
      #40;
      burst_clk = 1'b0;
      #40;
    end
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the flash command decoder
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, arst_n, op_start, op_done, timeout_flag_bit, reg_wr, reg_rd, irq;
  logic address_valid_strobe_n, write_strobe_n, burst_clk;
  logic upper_bank_q, read_blocked_q, suspend_read_q;
  logic [21:0] addr_pin, burst_addr_q, a;
  logic [15:0] dq_in, reg_wdata, reg_rdata, autosel_data_q;
  logic [3:0] reg_addr, latency_q, ready_cycles_q;
  logic [1:0] burst_type_q;
  logic [7:0] sector_q;
  logic [21:0] tbl [5] = '{22'h2f7fff, 22'h2f8000, 22'h2fe000, 22'h300000, 22'h3fe000};
  int errors, comparisons, ws, bt;
  flash_read_mode_burst_config dut (.clk_sys, .arst_n, .address_valid_strobe_n,
    .write_strobe_n, .burst_clk, .addr_pin, .dq_in, .op_start, .op_done,
    .timeout_flag_bit, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .latency_q, .burst_type_q, .burst_addr_q, .sector_q, .upper_bank_q,
    .read_blocked_q, .suspend_read_q, .autosel_data_q, .ready_cycles_q);
  flash_host_model host (.clk_sys, .address_valid_strobe_n, .write_strobe_n,
    .burst_clk, .addr_pin, .dq_in);
  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [3:0] ad, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check("register", reg_rdata, e);
  endtask
  // Unlock pair, then the setting in the third address; address bits 19..17 random, 21..20 zero
  task automatic configure(input int w, input int b);
    logic [2:0] hi;
    hi = 3'($urandom);
    host.wr(22'h000555, 16'h00aa);
    host.wr(22'h0002aa, 16'h0055);
    host.wr({2'h0, hi, 2'(b), 3'(w), 12'h555}, 16'h00c0);
    repeat (6) @(posedge clk_sys);
  endtask
  // Expected sector index from the word address
  function automatic int sect(input logic [21:0] x);
    if (x < 22'h2f8000) return int'(x >> 15);
    if (x < 22'h300000) return 95 + int'((x - 22'h2f8000) >> 13);
    if (x < 22'h3f8000) return 99 + int'((x - 22'h300000) >> 15);
    return 130 + int'((x - 22'h3f8000) >> 13);
  endfunction
  task automatic final_report;
    $display("Comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of some 20 us
  initial begin
    #400us;
    errors++;
    final_report;
  end
  initial begin
    {arst_n, op_start, op_done, timeout_flag_bit, reg_wr, reg_rd} = 6'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0;
    ws = $urandom(32'h500a);
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check("latency", latency_q, 7);
    check("burst", burst_type_q, 0);
    rchk(4'h3, flash_cmd_pkg::ST_READ);
    rchk(4'h2, 16'h0057);
    rchk(4'hf, 16'h0);
    reg_write(4'h1, 16'h0002);
    // Wait-state codes 0 to 5 with every burst code; the mask hides the config event
    for (bt = 0; bt < 4; bt++) begin
      for (ws = 0; ws < 6; ws++) begin
        configure(ws, bt);
        check("latency", latency_q, ws + 2);
        check("burst", burst_type_q, bt);
      end
    end
    check("irq", irq, 0);
    // Wrong data in the second unlock
    host.wr(22'h000555, 16'h00aa);
    host.wr(22'h0002aa, 16'h0012);
    repeat (6) @(posedge clk_sys);
    rchk(4'h3, flash_cmd_pkg::ST_READ);
    check("irq", irq, 1);
    rchk(4'h0, 16'h0003);
    reg_write(4'h0, 16'h0007);
    repeat (3) @(posedge clk_sys);
    check("irq", irq, 0);
    // Autoselect ignores a configuration until the reset command
    host.wr(22'h000555, 16'h00aa);
    host.wr(22'h0002aa, 16'h0055);
    host.wr(22'h000555, 16'h0090);
    host.latch(22'h000003);
    repeat (6) @(posedge clk_sys);
    check("autosel", autosel_data_q, 16'h0043);
    configure(2, 0);
    check("latency", latency_q, 7);
    host.wr(22'h0, 16'h00f0);
    repeat (6) @(posedge clk_sys);
    rchk(4'h3, flash_cmd_pkg::ST_READ);
    // Embedded operation completing by itself
    op_start <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rchk(4'h3, flash_cmd_pkg::ST_BUSY);
    op_done <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rchk(4'h3, flash_cmd_pkg::ST_READ);
    op_start <= 1'b0;
    op_done <= 1'b0;
    // Timeout holds the bank after the flag drops
    repeat (2) @(posedge clk_sys);
    op_start <= 1'b1;
    repeat (4) @(posedge clk_sys);
    timeout_flag_bit <= 1'b1;
    repeat (4) @(posedge clk_sys);
    timeout_flag_bit <= 1'b0;
    op_start <= 1'b0;
    rchk(4'h3, flash_cmd_pkg::ST_TIMEOUT);
    host.wr(22'h0, 16'h00f0);
    repeat (6) @(posedge clk_sys);
    rchk(4'h3, flash_cmd_pkg::ST_READ);
    // Suspend in sector 0; reads there are blocked, sector 1 is free
    host.wr(22'h0, 16'h00b0);
    repeat (6) @(posedge clk_sys);
    check("suspend", suspend_read_q, 1);
    check("blocked", read_blocked_q, 1);
    host.latch(22'h008000);
    repeat (6) @(posedge clk_sys);
    check("blocked", read_blocked_q, 0);
    host.wr(22'h0, 16'h0030);
    repeat (6) @(posedge clk_sys);
    check("suspend", suspend_read_q, 0);
    // Sector edges, then random addresses
    for (int i = 0; i < 9; i++) begin
      a = (i < 5) ? tbl[i] : 22'($urandom);
      host.latch(a);
      repeat (6) @(posedge clk_sys);
      check("sector", sector_q, sect(a));
      check("bank", upper_bank_q, a >= 22'h300000);
    end
    // 32-word wrap from the last random address, seven-cycle latency
    check("ready", ready_cycles_q, 7 + a[0]);
    host.burst(6);
    repeat (4) @(posedge clk_sys);
    check("burst addr", burst_addr_q, {a[21:5], 5'(a[4:0] + 5'h06)});
    // Continuous at the 40 MHz setting; odd start at a boundary crossing
    configure(2, 0);
    check("latency", latency_q, 4);
    host.latch(22'h00003f);
    repeat (6) @(posedge clk_sys);
    check("ready", ready_cycles_q, 7);
    host.burst(2);
    repeat (4) @(posedge clk_sys);
    check("burst addr", burst_addr_q, 22'h000041);
    // Hardware reset in mid-run must undo the four-cycle setting
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check("latency", latency_q, 7);
    final_report;
  end
endmodule
bind flash_read_mode_burst_config flash_cfg_chk chk (.clk_sys, .arst_n, .write_strobe_n,
  .reg_rd, .reg_rdata, .latency_q, .burst_type_q, .sector_q, .upper_bank_q,
  .autosel_data_q);
